/* acq_pkg.sv */
// Constants, register map and state type for the line scan acquisition sequencer.
// Assumes a single 10 MHz core clock and a plain strobe register port.
package acq_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PIX_W = 12;
  localparam int LINE_W = 12;
  localparam int FPA_W = 8;

  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_CMD = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] REG_LINE_START = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_LINE_PIXELS = 8'h10;
  localparam logic [ADDR_W-1:0] REG_FRAME_LINES = 8'h14;
  localparam logic [ADDR_W-1:0] REG_FRAMES_PER_ARM = 8'h18;
  localparam logic [ADDR_W-1:0] REG_LINES_MAX = 8'h1c;
  localparam logic [ADDR_W-1:0] REG_LAST_LINES = 8'h20;

  localparam int CTRL_CONT_BIT = 0;
  localparam int CTRL_ARM_EN_BIT = 1;
  localparam int CTRL_FRM_EN_BIT = 2;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_STOP_BIT = 1;
  localparam int CMD_ARM_BIT = 2;
  localparam int CMD_FRAME_BIT = 3;

  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [PIX_W-1:0] LINE_START_RST = 12'h000;
  localparam logic [PIX_W-1:0] LINE_PIXELS_RST = 12'h800;
  localparam logic [LINE_W-1:0] FRAME_LINES_RST = 12'h200;
  localparam logic [FPA_W-1:0] FPA_RST = 8'h01;
  localparam logic [FPA_W-1:0] FPA_MIN = 8'h01;

  localparam logic [LINE_W-1:0] LINES_ABS_MAX = 12'hfff;
  localparam logic [LINE_W-1:0] LINES_FLOOR = 12'h200;
  localparam logic [LINE_W-1:0] LINES_WIDE_MAX = 12'h800;
  localparam int SENSOR_PIXELS_DEF = 2048;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT_ARM = 2'b01,
    ST_WAIT_FRAME = 2'b11,
    ST_WAIT_LINE = 2'b10
  } acq_state_t;
endpackage : acq_pkg

/* geom_if.sv */
// Carrier for requested and checked frame geometry between sequencer and checker.
// Assumes both ends share the core clock domain.
`timescale 1ns/100ps
interface geom_if;
  import acq_pkg::*;
  logic [PIX_W-1:0] req_start;
  logic [PIX_W-1:0] req_pixels;
  logic [LINE_W-1:0] req_lines;
  logic [PIX_W-1:0] start;
  logic [PIX_W-1:0] pixels;
  logic [LINE_W-1:0] lines;
  logic [LINE_W-1:0] lines_max;
  modport calc (input req_start, req_pixels, req_lines, output start, pixels, lines, lines_max);
  modport user (output req_start, req_pixels, req_lines, input start, pixels, lines, lines_max);
endinterface : geom_if

/* frame_geometry.sv */
// Combinational geometry checker: clamps line window and frame height.
// Assumes requests come from registers in the same clock domain.
`timescale 1ns/100ps
module frame_geometry #(
  parameter int SENSOR_PIXELS = acq_pkg::SENSOR_PIXELS_DEF
) (
  input wire logic clk,
  input wire logic rst,
  geom_if.calc g
);
  import acq_pkg::*;
  localparam logic [PIX_W-1:0] SENS = PIX_W'(SENSOR_PIXELS);
  localparam logic [PIX_W-1:0] HALF = PIX_W'(SENSOR_PIXELS / 2);
  logic [PIX_W-1:0] room;

  initial begin
    if (SENSOR_PIXELS < 2 || SENSOR_PIXELS > 4095) $error("SENSOR_PIXELS out of range");
  end

  always_comb begin
    g.start = (g.req_start >= SENS) ? SENS - 12'h001 : g.req_start;
    room = SENS - g.start;
    if (g.req_pixels == 12'h000) begin
      g.pixels = 12'h001;
    end else if (g.req_pixels > room) begin
      g.pixels = room;
    end else begin
      g.pixels = g.req_pixels;
    end
    // Wide lines fill the line buffer sooner, so fewer of them fit a frame
    g.lines_max = (g.pixels > HALF) ? LINES_WIDE_MAX : LINES_ABS_MAX;
    if (g.req_lines == 12'h000) begin
      g.lines = 12'h001;
    end else if (g.req_lines > g.lines_max) begin
      g.lines = g.lines_max;
    end else begin
      g.lines = g.req_lines;
    end
  end

  AST_WINDOW_FITS: assert property (@(posedge clk) disable iff (rst)
    ({1'b0, g.start} + {1'b0, g.pixels}) <= {1'b0, SENS}) else $error("Line window overflow");
  AST_LINES_MAX_FLOOR: assert property (@(posedge clk) disable iff (rst)
    g.lines_max >= LINES_FLOOR && g.lines <= g.lines_max) else $error("Lines max bad");
endmodule : frame_geometry

/* arm_counter.sv */
// Counts accepted frame triggers since the last arm and flags the limit.
// Assumes clear and step are one-cycle pulses never high together.
`timescale 1ns/100ps
module arm_counter #(
  parameter int W = acq_pkg::FPA_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic step,
  input wire logic [W-1:0] limit,
  output logic reached
);
  logic [W-1:0] count_q;

  initial begin
    if (W < 1 || W > 16) $error("W out of range");
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_q <= '0;
    end else if (clear) begin
      count_q <= '0;
    end else if (step && count_q != {W{1'b1}}) begin
      count_q <= count_q + 1'b1;
    end
  end

  assign reached = (count_q >= limit);

  AST_COUNT_STEP: assert property (@(posedge clk) disable iff (rst)
    step && !clear && count_q != {W{1'b1}} |=> count_q == $past(count_q) + 1'b1)
    else $error("Frame count did not advance");
endmodule : arm_counter

/* acq_sequencer.sv */
// Acquisition sequencer: start/stop commands, arm/frame/line trigger states.
// Assumes trigger pulses are one cycle and synchronous to CORE_CLK.
`timescale 1ns/100ps
module acq_sequencer #(
  parameter int SENSOR_PIXELS = acq_pkg::SENSOR_PIXELS_DEF
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic [acq_pkg::ADDR_W-1:0] ADDR,
  input wire logic [acq_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [acq_pkg::DATA_W-1:0] RDATA,
  input wire logic ARM_TRIG,
  input wire logic FRAME_TRIG,
  input wire logic LINE_TRIG,
  input wire logic LINE_DONE,
  output logic EXPOSE_START,
  output logic FRAME_DONE,
  output logic FRAME_PARTIAL,
  output logic [acq_pkg::LINE_W-1:0] FRAME_LINES,
  output logic ACQ_ACTIVE,
  output logic [1:0] ACQ_STATE,
  output logic [acq_pkg::PIX_W-1:0] LINE_START,
  output logic [acq_pkg::PIX_W-1:0] LINE_PIXELS
);
  import acq_pkg::*;

  acq_state_t state_q;
  logic [2:0] ctrl_q;
  logic [PIX_W-1:0] req_start_q, req_pixels_q;
  logic [LINE_W-1:0] req_lines_q;
  logic [FPA_W-1:0] fpa_q;
  logic [LINE_W-1:0] act_lines_q, line_cnt_q, last_lines_q;
  logic [PIX_W-1:0] act_start_q, act_pixels_q;
  logic expo_q, stop_pend_q, active_q;
  logic expose_q, done_q, partial_q;
  logic [DATA_W-1:0] rdata_q;
  logic cont_mode, arm_en, frm_en;
  logic cmd_wr, start_cmd, stop_cmd, arm_ev, frm_ev;
  logic line_ok, line_end, frame_full, in_frame, stop_req, frame_end;
  logic arm_accept, frm_accept, fpa_reached, geom_pend;
  logic [LINE_W-1:0] lines_next, lines_ended;

  geom_if g ();

  assign g.req_start = req_start_q;
  assign g.req_pixels = req_pixels_q;
  assign g.req_lines = req_lines_q;

  frame_geometry #(.SENSOR_PIXELS(SENSOR_PIXELS)) u_geom (
    .clk(CORE_CLK),
    .rst(RST),
    .g(g)
  );

  assign cont_mode = ctrl_q[CTRL_CONT_BIT];
  assign arm_en = ctrl_q[CTRL_ARM_EN_BIT];
  assign frm_en = ctrl_q[CTRL_FRM_EN_BIT];
  assign cmd_wr = WR && ADDR == REG_CMD;
  assign start_cmd = cmd_wr && WDATA[CMD_START_BIT];
  assign stop_cmd = cmd_wr && WDATA[CMD_STOP_BIT];
  assign arm_ev = ARM_TRIG || (cmd_wr && WDATA[CMD_ARM_BIT]);
  // Frame trigger off: the frame trigger is valid whenever a frame can start
  assign frm_ev = !frm_en || FRAME_TRIG || (cmd_wr && WDATA[CMD_FRAME_BIT]);

  assign line_ok = state_q == ST_WAIT_LINE && LINE_TRIG && !expo_q && !stop_req;
  assign line_end = expo_q && LINE_DONE;
  assign lines_next = line_cnt_q + 12'h001;
  assign frame_full = line_end && lines_next == act_lines_q;
  assign in_frame = state_q == ST_WAIT_LINE && (expo_q || line_cnt_q != 12'h000);
  assign stop_req = stop_cmd || stop_pend_q;
  // A stop mid-exposure waits for the line to end, then closes the frame
  assign frame_end = frame_full || (stop_req && in_frame && (line_end || !expo_q));
  assign lines_ended = line_end ? lines_next : line_cnt_q;
  assign arm_accept = state_q == ST_WAIT_ARM && arm_ev && !stop_cmd;
  assign frm_accept = state_q == ST_WAIT_FRAME && frm_ev && !stop_cmd;
  // Compare clamped values, else a clamped request would look pending forever
  assign geom_pend = g.start != act_start_q || g.pixels != act_pixels_q
                     || g.lines != act_lines_q;

  arm_counter #(.W(FPA_W)) u_arm_cnt (
    .clk(CORE_CLK),
    .rst(RST),
    .clear(arm_accept || (state_q == ST_IDLE && start_cmd)),
    .step(frm_accept),
    .limit(fpa_q),
    .reached(fpa_reached)
  );

  // Software settings
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ctrl_q <= CTRL_RST;
      req_start_q <= LINE_START_RST;
      req_pixels_q <= LINE_PIXELS_RST;
      req_lines_q <= FRAME_LINES_RST;
      fpa_q <= FPA_RST;
    end else if (WR) begin
      unique case (ADDR)
        REG_CTRL: ctrl_q <= WDATA[2:0];
        REG_LINE_START: req_start_q <= (WDATA[31:12] != 20'h00000) ? 12'hfff : WDATA[11:0];
        REG_LINE_PIXELS: req_pixels_q <= (WDATA[31:12] != 20'h00000) ? 12'hfff : WDATA[11:0];
        REG_FRAME_LINES: begin
          req_lines_q <= (WDATA[31:12] != 20'h00000) ? LINES_ABS_MAX : WDATA[11:0];
        end
        REG_FRAMES_PER_ARM: begin
          if (WDATA[31:8] == 24'h000000 && WDATA[7:0] >= FPA_MIN) begin
            fpa_q <= WDATA[7:0];
          end
        end
        default: ;
      endcase
    end
  end

  // Geometry in use only follows requests while capture is off
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      act_start_q <= LINE_START_RST;
      act_pixels_q <= LINE_PIXELS_RST;
      act_lines_q <= FRAME_LINES_RST;
    end else if (state_q == ST_IDLE) begin
      act_start_q <= g.start;
      act_pixels_q <= g.pixels;
      act_lines_q <= g.lines;
    end
  end

  // Capture state
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (start_cmd) begin
            state_q <= arm_en ? ST_WAIT_ARM : ST_WAIT_FRAME;
          end
        end
        ST_WAIT_ARM: begin
          if (stop_cmd) begin
            state_q <= ST_IDLE;
          end else if (arm_ev) begin
            state_q <= ST_WAIT_FRAME;
          end
        end
        ST_WAIT_FRAME: begin
          if (stop_cmd) begin
            state_q <= ST_IDLE;
          end else if (frm_ev) begin
            state_q <= ST_WAIT_LINE;
          end
        end
        ST_WAIT_LINE: begin
          if (stop_cmd && !in_frame) begin
            state_q <= ST_IDLE;
          end else if (frame_end) begin
            if (!cont_mode || stop_req) begin
              state_q <= ST_IDLE;
            end else if (arm_en && fpa_reached) begin
              state_q <= ST_WAIT_ARM;
            end else begin
              state_q <= ST_WAIT_FRAME;
            end
          end
        end
      endcase
    end
  end

  // Own flop so the active pin is registered, not decoded from the state
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      active_q <= 1'b0;
    end else if (state_q == ST_IDLE) begin
      active_q <= start_cmd;
    end else if (state_q == ST_WAIT_LINE) begin
      active_q <= !((stop_cmd && !in_frame) || (frame_end && (!cont_mode || stop_req)));
    end else begin
      active_q <= !stop_cmd;
    end
  end

  // Line progress and pending stop
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      expo_q <= 1'b0;
      line_cnt_q <= 12'h000;
      stop_pend_q <= 1'b0;
    end else begin
      if (line_ok) begin
        expo_q <= 1'b1;
      end else if (line_end) begin
        expo_q <= 1'b0;
      end
      if (frm_accept || frame_end) begin
        line_cnt_q <= 12'h000;
      end else if (line_end) begin
        line_cnt_q <= lines_next;
      end
      if (frame_end || state_q == ST_IDLE) begin
        stop_pend_q <= 1'b0;
      end else if (stop_cmd && in_frame) begin
        stop_pend_q <= 1'b1;
      end
    end
  end

  // Outputs toward exposure and transmit paths
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      expose_q <= 1'b0;
      done_q <= 1'b0;
      partial_q <= 1'b0;
      last_lines_q <= 12'h000;
    end else begin
      expose_q <= line_ok;
      done_q <= frame_end;
      partial_q <= frame_end && !frame_full;
      if (frame_end) begin
        last_lines_q <= lines_ended;
      end
    end
  end

  // Register read port, data valid one cycle after the strobe
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      rdata_q <= '0;
    end else if (RD) begin
      unique case (ADDR)
        REG_CTRL: rdata_q <= {29'h0, ctrl_q};
        REG_STATUS: rdata_q <= {26'h0, geom_pend, stop_pend_q, expo_q,
                                state_q != ST_IDLE, state_q};
        REG_LINE_START: rdata_q <= {20'h0, req_start_q};
        REG_LINE_PIXELS: rdata_q <= {20'h0, req_pixels_q};
        REG_FRAME_LINES: rdata_q <= {20'h0, req_lines_q};
        REG_FRAMES_PER_ARM: rdata_q <= {24'h0, fpa_q};
        REG_LINES_MAX: rdata_q <= {20'h0, g.lines_max};
        REG_LAST_LINES: rdata_q <= {20'h0, last_lines_q};
        default: rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  assign RDATA = rdata_q;
  assign EXPOSE_START = expose_q;
  assign FRAME_DONE = done_q;
  assign FRAME_PARTIAL = partial_q;
  assign FRAME_LINES = last_lines_q;
  assign ACQ_ACTIVE = active_q;
  assign ACQ_STATE = state_q;
  assign LINE_START = act_start_q;
  assign LINE_PIXELS = act_pixels_q;

  AST_LINE_GATED: assert property (@(posedge CORE_CLK) disable iff (RST)
    state_q != ST_WAIT_LINE |=> !EXPOSE_START) else $error("Exposure outside frame");
  AST_LINE_EXPOSES: assert property (@(posedge CORE_CLK) disable iff (RST)
    state_q == ST_WAIT_LINE && LINE_TRIG && !expo_q && !stop_req |=> EXPOSE_START && expo_q)
    else $error("Valid line trigger lost");
  AST_ARM_BLOCKS_FRAME: assert property (@(posedge CORE_CLK) disable iff (RST)
    state_q == ST_WAIT_ARM && !arm_ev |=> state_q inside {ST_WAIT_ARM, ST_IDLE})
    else $error("Frame trigger taken while unarmed");
  AST_ARM_ADVANCE: assert property (@(posedge CORE_CLK) disable iff (RST)
    arm_accept |=> state_q == ST_WAIT_FRAME) else $error("Arm not taken");
  AST_FRAME_ADVANCE: assert property (@(posedge CORE_CLK) disable iff (RST)
    frm_accept |=> state_q == ST_WAIT_LINE ##0 line_cnt_q == 12'h000)
    else $error("Frame trigger not taken");
  AST_STOP_IDLE: assert property (@(posedge CORE_CLK) disable iff (RST)
    stop_cmd && state_q != ST_IDLE && !in_frame |=> state_q == ST_IDLE)
    else $error("Idle stop not immediate");
  AST_STOP_PARTIAL: assert property (@(posedge CORE_CLK) disable iff (RST)
    stop_pend_q && line_end && !frame_full |=> FRAME_DONE && FRAME_PARTIAL
    && state_q == ST_IDLE && FRAME_LINES == $past(lines_next)) else $error("Partial frame bad");
  AST_SINGLE_STOPS: assert property (@(posedge CORE_CLK) disable iff (RST)
    frame_end && !cont_mode |=> state_q == ST_IDLE ##1 !FRAME_DONE)
    else $error("Single frame kept capturing");
  AST_CONT_REARM: assert property (@(posedge CORE_CLK) disable iff (RST)
    frame_full && cont_mode && !stop_req && !(arm_en && fpa_reached)
    |=> state_q == ST_WAIT_FRAME) else $error("Continuous capture halted");
  AST_GEOM_HELD: assert property (@(posedge CORE_CLK) disable iff (RST)
    state_q != ST_IDLE && $past(state_q) != ST_IDLE |-> $stable(act_lines_q)
    && $stable(act_pixels_q)) else $error("Geometry changed mid capture");
  AST_FPA_RANGE: assert property (@(posedge CORE_CLK) disable iff (RST)
    fpa_q >= FPA_MIN) else $error("Frames per arm zero");
  AST_START_NEEDED: assert property (@(posedge CORE_CLK) disable iff (RST)
    state_q == ST_IDLE && !start_cmd |=> state_q == ST_IDLE && !EXPOSE_START)
    else $error("Capture without start command");
  AST_AUTO_ARM: assert property (@(posedge CORE_CLK) disable iff (RST)
    state_q == ST_IDLE && start_cmd && !arm_en |=> state_q == ST_WAIT_FRAME)
    else $error("Arm not generated internally");
  AST_ACTIVE_PIN: assert property (@(posedge CORE_CLK) disable iff (RST)
    ACQ_ACTIVE == (state_q != ST_IDLE)) else $error("Active flag out of step");
  AST_PARTIAL_WITH_DONE: assert property (@(posedge CORE_CLK) disable iff (RST)
    FRAME_PARTIAL |-> FRAME_DONE) else $error("Partial flag without frame end");

  COV_FULL_FRAME: cover property (@(posedge CORE_CLK) disable iff (RST) frame_full);
  COV_PARTIAL: cover property (@(posedge CORE_CLK) disable iff (RST) frame_end && !frame_full);
  COV_REARM: cover property (@(posedge CORE_CLK) disable iff (RST)
    frame_end && state_q == ST_WAIT_LINE && arm_en && fpa_reached && cont_mode && !stop_req);
  COV_STOP_MID_LINE: cover property (@(posedge CORE_CLK) disable iff (RST) stop_cmd && expo_q);
  COV_SINGLE_DONE: cover property (@(posedge CORE_CLK) disable iff (RST) frame_end && !cont_mode);
endmodule : acq_sequencer

/* trig_partner.sv */
// Far side model: answers each exposure start with a line-done pulse.
// Assumes the bench sets the latency before each line trigger.
`timescale 1ns/100ps
module trig_partner (
  input wire logic clk,
  input wire logic rst,
  input wire logic expose_start,
  input wire logic [3:0] lat,
  output logic line_done
);
  logic [4:0] cnt_q;

  // Done only ever follows an exposure start
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 5'h00;
      line_done <= 1'b0;
    end else begin
      line_done <= 1'b0;
      if (expose_start) begin
        cnt_q <= {1'b0, lat} + 5'h01;
      end else if (cnt_q == 5'h01) begin
        line_done <= 1'b1;
        cnt_q <= 5'h00;
      end else if (cnt_q != 5'h00) begin
        cnt_q <= cnt_q - 5'h01;
      end
    end
  end
endmodule : trig_partner

/* acq_sequencer_bench.sv */
// Self-checking bench for the acquisition sequencer.
// Assumes the sequencer and the trigger partner model are compiled first.
`timescale 1ns/100ps
module acq_sequencer_bench;
  import acq_pkg::*;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rd_p = 1'b0;
  logic arm = 1'b0, frm = 1'b0, lt = 1'b0, line_done, exp_s, f_done, f_part, act;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [DATA_W-1:0] wdata = 32'h0, rdata;
  logic [LINE_W-1:0] f_lines;
  logic [1:0] st;
  logic [PIX_W-1:0] l_start, l_pix;
  logic [3:0] lat = 4'h1;
  logic [DATA_W-1:0] rq[$];
  logic [12:0] fq[$];
  int failures = 0, compares = 0, n_exp = 0, cycles = 0, seed = 83978;

  always #50 clk = ~clk;

  acq_sequencer i_dut (.CORE_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .ARM_TRIG(arm), .FRAME_TRIG(frm), .LINE_TRIG(lt),
    .LINE_DONE(line_done), .EXPOSE_START(exp_s), .FRAME_DONE(f_done),
    .FRAME_PARTIAL(f_part), .FRAME_LINES(f_lines), .ACQ_ACTIVE(act), .ACQ_STATE(st),
    .LINE_START(l_start), .LINE_PIXELS(l_pix));
  trig_partner i_partner (.clk(clk), .rst(rst), .expose_start(exp_s), .lat(lat),
    .line_done(line_done));

  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      failures++;
      $display("Error %0t val got %h exp %h", $time, g, e);
    end
  endtask : chk_val

  task automatic chk_rd(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      failures++;
      $display("Error %0t rd got %h exp %h", $time, g, e);
    end
  endtask : chk_rd

  task automatic chk_frm(input logic [12:0] g, input logic [12:0] e);
    compares++;
    if (g !== e) begin
      failures++;
      $display("Error %0t frame got %h exp %h", $time, g, e);
    end
  endtask : chk_frm

  // Monitor: oldest note is taken whenever a result appears
  always @(posedge clk) begin
    rd_p <= rd;
    cycles++;
    if (rd_p === 1'b1) chk_rd(rdata, rq.size() ? rq.pop_front() : 32'hdead);
    if (f_done === 1'b1) chk_frm({f_part, f_lines}, fq.size() ? fq.pop_front() : 13'h1fff);
    if (exp_s === 1'b1) n_exp++;
    if (cycles == 20000) begin
      failures++;
      summarize();
    end
  end

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    rq.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_reg

  task automatic trig(input int k);
    @(posedge clk);
    if (k == 0) arm <= 1'b1;
    if (k == 1) frm <= 1'b1;
    if (k == 2) lt <= 1'b1;
    @(posedge clk);
    {arm, frm, lt} <= 3'h0;
  endtask : trig

  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask : settle

  task automatic wt_done();
    int i;
    i = 0;
    do @(posedge clk); while (line_done !== 1'b1 && ++i < 40);
    chk_val(i < 40, 1);
    @(posedge clk);
  endtask : wt_done

  task automatic lines(input int n);
    repeat (n) begin
      lat <= $random(seed) & 3;
      trig(2);
      wt_done();
    end
  endtask : lines

  task automatic summarize();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_reg(REG_LINE_PIXELS, 32'h800);
    rd_reg(REG_FRAME_LINES, 32'h200);
    rd_reg(REG_FRAMES_PER_ARM, 32'h1);
    rd_reg(REG_LINES_MAX, 32'h800);
    rd_reg(REG_STATUS, 32'h0);
    wr_reg(8'h40, $random(seed));
    rd_reg(8'h40, 32'h0);
    $display("reset and map test done");
    wr_reg(REG_FRAMES_PER_ARM, 32'h0);
    rd_reg(REG_FRAMES_PER_ARM, 32'h1);
    wr_reg(REG_FRAMES_PER_ARM, 32'h100);
    rd_reg(REG_FRAMES_PER_ARM, 32'h1);
    wr_reg(REG_FRAMES_PER_ARM, 32'hff);
    rd_reg(REG_FRAMES_PER_ARM, 32'hff);
    wr_reg(REG_FRAME_LINES, 32'h1234);
    rd_reg(REG_FRAME_LINES, 32'hfff);
    wr_reg(REG_LINE_START, 32'h700);
    wr_reg(REG_LINE_PIXELS, 32'h200);
    settle();
    chk_val({20'h0, l_start} + {20'h0, l_pix} <= 32'd2048, 1);
    chk_val(l_pix, 32'h100);
    rd_reg(REG_LINES_MAX, 32'hfff);
    wr_reg(REG_LINE_START, 32'h0);
    wr_reg(REG_LINE_PIXELS, 32'h800);
    $display("geometry limits test done");
    wr_reg(REG_FRAME_LINES, 32'h2);
    wr_reg(REG_FRAMES_PER_ARM, 32'h1);
    wr_reg(REG_CTRL, 32'h1);
    trig(2);
    settle();
    chk_val(n_exp, 0);
    wr_reg(REG_CMD, 32'h1);
    settle();
    chk_val(st, 2'b10);
    fq.push_back({1'b0, 12'h002});
    lines(2);
    wr_reg(REG_FRAME_LINES, 32'h3);
    rd_reg(REG_STATUS, 32'h26);
    fq.push_back({1'b0, 12'h002});
    lines(2);
    fq.push_back({1'b1, 12'h001});
    lat <= 4'h8;
    trig(2);
    wr_reg(REG_CMD, 32'h2);
    wt_done();
    settle();
    chk_val(st, 2'b00);
    chk_val(n_exp, 5);
    rd_reg(REG_LAST_LINES, 32'h1);
    $display("continuous test done");
    wr_reg(REG_CTRL, 32'h0);
    wr_reg(REG_CMD, 32'h1);
    fq.push_back({1'b0, 12'h003});
    lines(1);
    wr_reg(REG_FRAME_LINES, 32'h1);
    lines(2);
    settle();
    chk_val(act, 0);
    trig(2);
    settle();
    chk_val(n_exp, 8);
    $display("single frame test done");
    wr_reg(REG_FRAMES_PER_ARM, 32'h2);
    wr_reg(REG_CTRL, 32'h7);
    wr_reg(REG_CMD, 32'h1);
    settle();
    chk_val(st, 2'b01);
    trig(1);
    settle();
    chk_val(st, 2'b01);
    trig(0);
    settle();
    chk_val(st, 2'b11);
    trig(1);
    settle();
    chk_val(st, 2'b10);
    fq.push_back({1'b0, 12'h001});
    lines(1);
    settle();
    chk_val(st, 2'b11);
    trig(1);
    fq.push_back({1'b0, 12'h001});
    lines(1);
    settle();
    chk_val(st, 2'b01);
    wr_reg(REG_CMD, 32'h4);
    settle();
    chk_val(st, 2'b11);
    wr_reg(REG_CMD, 32'h8);
    settle();
    chk_val(st, 2'b10);
    wr_reg(REG_CMD, 32'h2);
    settle();
    chk_val(st, 2'b00);
    $display("arm trigger test done");
    wr_reg(REG_CTRL, 32'h5);
    wr_reg(REG_CMD, 32'h1);
    settle();
    chk_val(st, 2'b11);
    wr_reg(REG_CMD, 32'h2);
    settle();
    chk_val(st, 2'b00);
    chk_val(fq.size(), 0);
    $display("auto arm test done");
    summarize();
  end
endmodule : acq_sequencer_bench
